//--- design/ctei_pkg.sv
package ctei_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ADDR = 8'h04;
  localparam logic [7:0] ADDR_BUF = 8'h08;
  localparam logic [7:0] ADDR_FLIP = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;
  // Control bit positions
  localparam int CTRL_MAP_BIT = 0;
  localparam int CTRL_SSH_BIT = 1;
  // Command codes written to ADDR_CMD
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  // Status bit positions
  localparam int ST_CE_BIT = 0;
  localparam int ST_UCE_BIT = 1;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  // Geometry
  localparam int TAG_W = 24;
  localparam int ECC_W = 6;
  localparam int IDX_W = 4;
endpackage : ctei_pkg

//--- design/ctei_ecc.sv
`timescale 1ns/1ps
`default_nettype none
// Extended Hamming code: tells one flipped bit from two flipped bits
module ctei_ecc #(
  parameter int DW = 24,
  parameter int CW = 6
) (
  // Data in
  input wire logic [DW-1:0] data,
  // Check bits
  output logic [CW-1:0] check,
  // Compare against stored check
  input wire logic [CW-1:0] stored,
  output logic single_err,
  output logic double_err
);
  // Position of data bit b: the b-th code from 3 up that is no power of
  // two, so any two flipped bits leave a nonzero syndrome
  function automatic int code_of(input int b);
    int cnt;
    cnt = 0;
    code_of = 0;
    for (int c = 3; c < 256; c++) begin
      if ((c & (c - 1)) != 0) begin
        if (cnt == b && code_of == 0) code_of = c;
        cnt++;
      end
    end
  endfunction : code_of

  logic [CW-2:0] ham;
  logic [CW-2:0] syn;
  // Each Hamming bit covers the data bits whose position has it set
  for (genvar k = 0; k < CW - 1; k++) begin : g_ham
    logic [DW-1:0] sel;
    for (genvar b = 0; b < DW; b++) begin : g_bit
      assign sel[b] = (((code_of(b) >> k) & 1) != 0) ? data[b] : 1'b0;
    end
    assign ham[k] = ^sel;
  end
  // Overall bit makes the whole word even, check bits included
  assign check = {(^data) ^ (^ham), ham};
  assign syn = ham ^ stored[CW-2:0];
  // Odd overall parity means one flip; even with a syndrome means two
  assign single_err = ^{data, stored};
  assign double_err = !(^{data, stored}) && (|syn);
endmodule : ctei_ecc
`default_nettype wire

//--- design/ctei_top.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Mapped tag memory suppresses ECC alarms
// - Normal cache use keeps detection active
// - Self-test mode keeps detection active
// - Read, flip, write back, reread
// - One flip correctable, two uncorrectable
module ctei_top #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Cache-side lookup port
  input wire logic cache_rd,
  input wire logic [ctei_pkg::IDX_W-1:0] cache_idx,
  output logic [ctei_pkg::TAG_W-1:0] cache_tag,
  // Alarms and interrupt
  output logic correctable_error_alarm,
  output logic uncorrectable_error_alarm,
  output logic irq
);
  localparam int TW = ctei_pkg::TAG_W;
  localparam int CW = ctei_pkg::ECC_W;
  localparam int IW = ctei_pkg::IDX_W;

  // Storage: data plus check bits per entry
  logic [TW-1:0] tag_mem [DEPTH];
  logic [CW-1:0] chk_mem [DEPTH];
  logic [1:0] ctrl;
  logic [IW-1:0] idx;
  logic [TW+CW-1:0] readback_bitflip_buffer;
  logic [1:0] stat;
  logic [1:0] mask;

  // Bus decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == ctei_pkg::ADDR_CTRL;
  wire hit_addr = paddr == ctei_pkg::ADDR_ADDR;
  wire hit_buf = paddr == ctei_pkg::ADDR_BUF;
  wire hit_flip = paddr == ctei_pkg::ADDR_FLIP;
  wire hit_stat = paddr == ctei_pkg::ADDR_STAT;
  wire hit_mask = paddr == ctei_pkg::ADDR_MASK;
  wire hit_cmd = paddr == ctei_pkg::ADDR_CMD;
  wire mapped = hit_ctrl | hit_addr | hit_buf | hit_flip | hit_stat | hit_mask | hit_cmd;
  wire cmd_rd = wr && hit_cmd && (pwdata[1:0] == ctei_pkg::CMD_READ);
  wire cmd_wb = wr && hit_cmd && (pwdata[1:0] == ctei_pkg::CMD_WRITE);
  wire test_mapping_control = ctrl[ctei_pkg::CTRL_MAP_BIT];
  wire sram_test_support_mode = ctrl[ctei_pkg::CTRL_SSH_BIT];

  // Check the read path: test read or cache read share one checker
  wire [IW-1:0] chk_idx = cmd_rd ? idx : cache_idx;
  wire chk_valid = cmd_rd || cache_rd;
  wire [TW-1:0] rd_data = tag_mem[chk_idx];
  wire [CW-1:0] rd_chk = chk_mem[chk_idx];
  logic [CW-1:0] wr_chk_unused;
  logic se;
  logic de;
  ctei_ecc #(.DW(TW), .CW(CW)) u_ecc (
    .data(rd_data),
    .check(wr_chk_unused),
    .stored(rd_chk),
    .single_err(se),
    .double_err(de)
  );
  // Detection gated only by mapping; self-test mode leaves it on.
  // Mapping turns the tag memory into a plain word store, so its check
  // is dropped there; self-test must still raise alarms and keeps it.
  wire det_en = !test_mapping_control;
  wire ev_ce = chk_valid && det_en && se;
  wire ev_uce = chk_valid && det_en && de;

  // Fresh check bits for normal writes through the mapped window
  logic [CW-1:0] gen_chk;
  ctei_ecc #(.DW(TW), .CW(CW)) u_gen (
    .data(pwdata[TW-1:0]),
    .check(gen_chk),
    .stored({CW{1'b0}}),
    .single_err(),
    .double_err()
  );
  // Direct init only while mapped and in self-test; a plain word write
  // then lands with fresh check bits, so the memory starts clean
  wire map_wr = wr && hit_buf && test_mapping_control && sram_test_support_mode;

  // Write strobes, each taken at the completing edge of the access
  // Qualifying by pready keeps a stretched access from acting twice
  wire wr_go = wr && pready;
  wire wr_ctrl = wr_go && hit_ctrl;
  wire wr_addr = wr_go && hit_addr;
  wire wr_buf = wr_go && hit_buf;
  wire wr_flip = wr_go && hit_flip;
  wire wr_stat = wr_go && hit_stat;
  wire wr_mask = wr_go && hit_mask;
  // Commands act once, at the same edge as a register write would
  wire ld_buf = cmd_rd && pready;
  wire wb_mem = cmd_wb && pready;
  wire init_mem = map_wr && pready;

  // Read values, zero-extended to the bus width
  wire [31:0] rd_ctrl = {30'h0, ctrl};
  wire [31:0] rd_addr = {{(32 - IW){1'b0}}, idx};
  wire [31:0] rd_buf = {{(32 - TW){1'b0}}, readback_bitflip_buffer[TW-1:0]};
  wire [31:0] rd_flip = {{(32 - CW){1'b0}}, readback_bitflip_buffer[TW+CW-1:TW]};
  wire [31:0] rd_stat = {30'h0, stat};
  wire [31:0] rd_mask = {30'h0, mask};
  // Read mux; command and unmapped offsets read as zero
  // Reads have no side effects, so polling the status is safe
  wire [31:0] rd_mux =
    hit_ctrl ? rd_ctrl :
    hit_addr ? rd_addr :
    hit_buf ? rd_buf :
    hit_flip ? rd_flip :
    hit_stat ? rd_stat :
    hit_mask ? rd_mask : 32'h0;

  // Event and clear vectors, one bit per alarm
  wire [1:0] ev = {ev_uce, ev_ce};
  wire [1:0] w1c = wr_stat ? pwdata[1:0] : 2'h0;
  logic [1:0] next_stat;
  // Sticky status per bit; a new event beats a clear in the same cycle,
  // so an alarm is never lost to an acknowledge that races it
  for (genvar s = 0; s < 2; s++) begin : g_stat
    assign next_stat[s] = ev[s] | (stat[s] & ~w1c[s]);
  end

  // APB answer: no wait states, slverr on unmapped addresses
  // pready rises in the cycle after setup; read data is captured in
  // setup so it stands through the access
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Control registers
  // Upper pwdata bits are ignored rather than faulted
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= ctei_pkg::CTRL_RST;
      mask <= ctei_pkg::MASK_RST;
      idx <= '0;
    end else begin
      if (wr_ctrl) ctrl <= pwdata[1:0];
      if (wr_mask) mask <= pwdata[1:0];
      if (wr_addr) idx <= pwdata[IW-1:0];
    end
  end

  // Readback buffer: load, flip by XOR, write back unchanged
  // XOR rather than store lets software flip bits without a read first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      readback_bitflip_buffer <= '0;
    end else if (ld_buf) begin
      readback_bitflip_buffer <= {rd_chk, rd_data};
    end else if (wr_buf) begin
      readback_bitflip_buffer[TW-1:0] <= readback_bitflip_buffer[TW-1:0] ^ pwdata[TW-1:0];
    end else if (wr_flip) begin
      readback_bitflip_buffer[TW+CW-1:TW] <= readback_bitflip_buffer[TW+CW-1:TW] ^ pwdata[CW-1:0];
    end
  end

  // Tag memory: write-back keeps corrupted check bits as-is
  // Not reset: contents are undefined until software initialises them
  always_ff @(posedge clk) begin
    if (wb_mem) begin
      tag_mem[idx] <= readback_bitflip_buffer[TW-1:0];
      chk_mem[idx] <= readback_bitflip_buffer[TW+CW-1:TW];
    end else if (init_mem) begin
      tag_mem[idx] <= pwdata[TW-1:0];
      chk_mem[idx] <= gen_chk;
    end
  end

  // Sticky alarms; pins copy the status so both move at one edge
  // irq is a level: it follows the masked status until software clears it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat <= 2'h0;
      correctable_error_alarm <= 1'b0;
      uncorrectable_error_alarm <= 1'b0;
      irq <= 1'b0;
    end else begin
      stat <= next_stat;
      correctable_error_alarm <= next_stat[ctei_pkg::ST_CE_BIT];
      uncorrectable_error_alarm <= next_stat[ctei_pkg::ST_UCE_BIT];
      irq <= |(next_stat & mask);
    end
  end

  // Cache lookup data, raw as stored; a test read in the same cycle
  // takes the shared checker, so lookups should avoid command cycles
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cache_tag <= '0;
    end else if (cache_rd) begin
      cache_tag <= rd_data;
    end
  end
endmodule : ctei_top
`default_nettype wire

//--- verification/ctei_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ctei_top_checker (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Cache lookup and alarms
  input wire logic cache_rd,
  input wire logic correctable_error_alarm,
  input wire logic uncorrectable_error_alarm,
  input wire logic irq
);
  logic map;
  logic [1:0] seen_mask;
  wire logic acc = psel && penable && pready && pwrite;
  wire logic rd_done = acc && paddr == ctei_pkg::ADDR_CMD
    && pwdata[1:0] == ctei_pkg::CMD_READ;
  // Mapping state mirrored from bus writes, since the register is internal
  always_ff @(posedge clk) begin
    if (!nrst) begin
      map <= 1'h0;
      seen_mask <= 2'h0;
    end else if (acc && paddr == ctei_pkg::ADDR_CTRL) begin
      map <= pwdata[0];
    end else if (acc && paddr == ctei_pkg::ADDR_MASK) begin
      seen_mask <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Alarms only follow a reread or a cache lookup
  sequence s_cause;
    $past(rd_done) || $past(cache_rd) || $past(cache_rd, 2);
  endsequence
  sequence s_clr(b);
    $past(acc && paddr == ctei_pkg::ADDR_STAT && b);
  endsequence
  property p_ce_cause; $rose(correctable_error_alarm) |-> s_cause; endproperty
  property p_uce_cause; $rose(uncorrectable_error_alarm) |-> s_cause; endproperty
  property p_map_quiet;
    $rose(correctable_error_alarm) || $rose(uncorrectable_error_alarm) |-> !map;
  endproperty
  property p_ce_hold; $fell(correctable_error_alarm) |-> s_clr(pwdata[0]); endproperty
  property p_uce_hold; $fell(uncorrectable_error_alarm) |-> s_clr(pwdata[1]); endproperty
  // irq and the alarms land at one edge; a mask write reaches irq one edge after the mask lands
  property p_irq;
    irq == |({uncorrectable_error_alarm, correctable_error_alarm} & seen_mask);
  endproperty
  property p_ready; psel && !penable |=> pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  a_ce_cause: assert property (p_ce_cause) else $error("stray correctable alarm");
  a_uce_cause: assert property (p_uce_cause) else $error("stray uncorrectable alarm");
  a_map_quiet: assert property (p_map_quiet) else $error("alarm while mapped");
  a_ce_hold: assert property (p_ce_hold) else $error("correctable alarm dropped");
  a_uce_hold: assert property (p_uce_hold) else $error("uncorrectable alarm dropped");
  a_irq: assert property (p_irq) else $error("irq not matching masked alarms");
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_err: assert property (p_err) else $error("error without ready");
endmodule : ctei_top_checker
bind ctei_top ctei_top_checker u_chk (.clk, .nrst, .psel, .penable, .pwrite, .pready,
  .pslverr, .paddr, .pwdata, .cache_rd, .correctable_error_alarm,
  .uncorrectable_error_alarm, .irq);
`default_nettype wire

//--- verification/ctei_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ctei_top_tb;
  logic clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic cache_rd = 1'h0, pready, pslverr, serr, irq;
  logic correctable_error_alarm, uncorrectable_error_alarm;
  logic [3:0] cache_idx = 4'h0;
  logic [7:0] paddr = 8'h0;
  logic [ctei_pkg::TAG_W-1:0] cache_tag;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [2:0] e;
  int err_count = 0, checked = 0, cyc = 0;
  ctei_top DUT (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cache_rd, .cache_idx, .cache_tag, .correctable_error_alarm,
    .uncorrectable_error_alarm, .irq);
  initial forever #25 clk = ~clk;
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) if (++cyc == 4000) begin
    err_count++;
    summarize();
  end
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One transfer; a fresh edge first so no strobe is set twice in a step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdata = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  // Alarm and irq view once the registered alarms have landed
  task automatic al(input logic [2:0] x);
    repeat (2) @(posedge clk);
    #1 chk({29'h0, irq, uncorrectable_error_alarm, correctable_error_alarm}, {29'h0, x});
  endtask : al
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    xfer(1'h0, 8'hfc, 32'h1);
    chk({serr, rdata[30:0]}, 32'h80000000);
    al(3'h0);
    xfer(1'h1, ctei_pkg::ADDR_ADDR, 32'h5);
    xfer(1'h1, ctei_pkg::ADDR_MASK, 32'h1);
    // Loop: one or two flips, in normal, self-test and mapped modes
    for (int i = 0; i < 6; i++) begin
      e = i > 3 ? 3'h0 : i % 2 ? 3'h2 : 3'h5;
      xfer(1'h1, ctei_pkg::ADDR_CTRL, 32'h3);
      xfer(1'h1, ctei_pkg::ADDR_BUF, 32'ha5c3); // Clean word, fresh check bits
      xfer(1'h1, ctei_pkg::ADDR_CTRL, i > 3 ? 32'h1 : i > 1 ? 32'h2 : 32'h0);
      xfer(1'h1, ctei_pkg::ADDR_CMD, 32'h1);
      xfer(1'h1, ctei_pkg::ADDR_BUF, i % 2 ? 32'h3 : 32'h1);
      xfer(1'h1, ctei_pkg::ADDR_CMD, 32'h2);
      xfer(1'h1, ctei_pkg::ADDR_CMD, 32'h1);
      al(e);
      repeat (5) @(posedge clk);
      xfer(1'h0, ctei_pkg::ADDR_STAT, 32'h0);
      chk(rdata, {30'h0, e[1:0]});
      xfer(1'h1, ctei_pkg::ADDR_STAT, 32'h3);
      al(3'h0);
      @(posedge clk);
      cache_idx <= 4'h5;
      cache_rd <= 1'h1;
      @(posedge clk);
      cache_rd <= 1'h0;
      al(e);
      chk({8'h0, cache_tag}, i % 2 ? 32'ha5c0 : 32'ha5c2);
      xfer(1'h1, ctei_pkg::ADDR_STAT, 32'h3);
    end
    summarize();
  end
endmodule : ctei_top_tb
`default_nettype wire
